// *** hdl/cpubl_exec_core.sv ***
// Notes on behaviour
// - io bit set skips next instruction, pc plus 2 or 3, 1/2/3 clocks.
// - flag branch jumps to pc plus k plus one when matched; 2 clocks taken, else 1.
// - signed ge and lt branches test N xor V equal zero or one.
// - overflow branches jump relative on V set or clear, flags untouched.
// - half-carry and T branches jump only when that flag equals wanted value.
// - post-increment load reads at pointer, writes register, then bumps pointer; 2 clocks.
// - pre-decrement load drops pointer first, then reads at new value; 2 clocks.
// - displaced load reads at Y or Z plus q, pointer kept; 2 clocks.
// - indirect stores write at pointer with post-inc, pre-dec or displacement; 2 clocks.
// - direct load and store use the instruction address; 2 clocks each.
// - program read fetches byte at Z into R0 or Rd, optional Z bump; 3 clocks.
// - push writes stack, pop reads stack top; 2 clocks, flags untouched.
// - io bit set and clear force only bit b, flags untouched; 2 clocks.
// - logical shifts fill zero, rotates use carry; Z C N V updated, 1 clock.
// - arithmetic right shift keeps bit 7; Z C N V updated, 1 clock.
// - bit store copies register bit to T; bit load copies T back; 1 clock.
// - flag set and clear touch exactly one status flag in 1 clock.
// - sleep takes 3 clocks, flags untouched; watchdog kick and no-op take 1.
`timescale 1ns/1ps
`default_nettype none

module cpubl_exec_core (
	input  wire logic                     mclk,
	input  wire logic                     rst,
	input  wire logic                     ce,
	input  wire logic                     instr_valid,
	input  wire cpubl_pkg::cpubl_instr_t  instr,
	output logic                          instr_ready,
	output logic                          retire,
	output logic [15:0]                   pc,
	output logic [15:0]                   sp,
	output logic [7:0]                    status_flags,
	output var cpubl_pkg::cpubl_dmem_req_t dmem_req,
	input  wire logic [7:0]               dmem_rdata,
	output var cpubl_pkg::cpubl_pmem_req_t pmem_req,
	input  wire logic [7:0]               pmem_rdata,
	output logic [5:0]                    io_addr,
	input  wire logic [7:0]               io_rdata,
	output var cpubl_pkg::cpubl_io_wr_t   io_wr,
	output logic                          wdt_kick,
	output logic                          sleep_req,
	input  wire logic [4:0]               view_idx,
	output logic [7:0]                    view_data
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		cpubl_pkg::cpubl_fsm_t       fsm;
		logic [1:0]                  wait_cnt;
		cpubl_pkg::cpubl_instr_t     cur;
		logic [15:0]                 pc;
		logic [15:0]                 sp;
		logic [7:0]                  flags;
		logic [31:0][7:0]            rf;
		cpubl_pkg::cpubl_dmem_req_t  dmem;
		cpubl_pkg::cpubl_pmem_req_t  pmem;
		cpubl_pkg::cpubl_io_wr_t     io;
		logic                        retire;
		logic                        wdt_kick;
		logic                        sleep_req;
		logic [7:0]                  view;
	} cpubl_state_t;

	cpubl_state_t s_reg;
	cpubl_state_t s_next;

	logic        accept;
	logic [4:0]  ptr_lo;
	logic [4:0]  cur_lo;
	logic [15:0] ptr_val;
	logic [15:0] cur_ptr_val;
	logic [15:0] ptr_addr;
	logic [15:0] z_val;
	logic [15:0] k_ext;
	logic        br_taken;
	logic [7:0]  bit_mask;
	logic [7:0]  sh_res;
	logic        sh_z;
	logic        sh_c;
	logic        sh_n;
	logic        sh_v;

	////////////////////////////////////////////////////////////////////////////////
	// outputs straight from state
	assign instr_ready  = ce && (s_reg.fsm == cpubl_pkg::S_IDLE);
	assign accept       = instr_valid && instr_ready;
	assign retire       = s_reg.retire;
	assign pc           = s_reg.pc;
	assign sp           = s_reg.sp;
	assign status_flags = s_reg.flags;
	assign dmem_req     = s_reg.dmem;
	assign pmem_req     = s_reg.pmem;
	assign io_wr        = s_reg.io;
	assign wdt_kick     = s_reg.wdt_kick;
	assign sleep_req    = s_reg.sleep_req;
	assign view_data    = s_reg.view;

	// io read address follows the held instruction while busy
	assign io_addr = (s_reg.fsm == cpubl_pkg::S_BUSY) ? s_reg.cur.io_addr : instr.io_addr;

	////////////////////////////////////////////////////////////////////////////////
	// pointer pairs as 16-bit values
	assign ptr_lo      = 5'(cpubl_pkg::PTR_BASE_IDX + 2 * int'(instr.ptr));
	assign ptr_val     = {s_reg.rf[ptr_lo | 5'h01], s_reg.rf[ptr_lo]};
	assign z_val       = {s_reg.rf[5'h1F], s_reg.rf[5'h1E]};
	assign cur_lo      = (s_reg.cur.op == cpubl_pkg::OP_PROGRAM_MEMORY_READ ||
	                      s_reg.cur.op == cpubl_pkg::OP_PROGRAM_MEMORY_READ_R0) ?
	                     5'h1E : 5'(cpubl_pkg::PTR_BASE_IDX + 2 * int'(s_reg.cur.ptr));
	assign cur_ptr_val = {s_reg.rf[cur_lo | 5'h01], s_reg.rf[cur_lo]};
	assign k_ext       = {{9{instr.koff[6]}}, instr.koff};
	assign bit_mask    = 8'h01 << instr.bit_sel;

	// effective data address per addressing mode
	always_comb begin
		case (instr.amode)
			cpubl_pkg::AM_PREDEC:    ptr_addr = ptr_val - 16'h0001;
			cpubl_pkg::AM_DISPLACED: ptr_addr = ptr_val + {10'h000, instr.q};
			default:                 ptr_addr = ptr_val;
		endcase
	end

	// branch condition on the status flags
	always_comb begin
		case (instr.op)
			cpubl_pkg::OP_BRANCH_STATUS_BIT_SET:   br_taken = s_reg.flags[instr.bit_sel];
			cpubl_pkg::OP_BRANCH_STATUS_BIT_CLEAR: br_taken = !s_reg.flags[instr.bit_sel];
			cpubl_pkg::OP_BRANCH_SIGNED_GE:
				br_taken = !(s_reg.flags[cpubl_pkg::FLAG_N] ^ s_reg.flags[cpubl_pkg::FLAG_V]);
			cpubl_pkg::OP_BRANCH_SIGNED_LT:
				br_taken = s_reg.flags[cpubl_pkg::FLAG_N] ^ s_reg.flags[cpubl_pkg::FLAG_V];
			default:                               br_taken = 1'b0;
		endcase
	end

	cpubl_shift_unit #(
		.W (8)
	) u_shift (
		.sel  (instr.op),
		.a    (s_reg.rf[instr.rd]),
		.c_in (s_reg.flags[cpubl_pkg::FLAG_C]),
		.res  (sh_res),
		.z    (sh_z),
		.c    (sh_c),
		.n    (sh_n),
		.v    (sh_v)
	);

	////////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [1:0]  wait_n;
		logic [15:0] sp_up;
		wait_n = 2'h0;
		sp_up  = s_reg.sp + 16'h0001;
		s_next = s_reg;
		s_next.retire    = 1'b0;
		s_next.wdt_kick  = 1'b0;
		s_next.sleep_req = 1'b0;
		s_next.view      = s_reg.rf[view_idx];
		case (s_reg.fsm)
			cpubl_pkg::S_IDLE: begin
				if (instr_valid) begin
					s_next.cur    = instr;
					s_next.pc     = s_reg.pc + 16'h0001;
					s_next.retire = 1'b1;
					case (instr.op)
						cpubl_pkg::OP_SLEEP: begin
							s_next.sleep_req = 1'b1;
							wait_n = 2'(cpubl_pkg::CYC_SLEEP - 1);
						end
						cpubl_pkg::OP_WATCHDOG_KICK: s_next.wdt_kick = 1'b1;
						cpubl_pkg::OP_SKIP_IF_IO_BIT_SET: begin
							if (io_rdata[instr.bit_sel]) begin
								if (instr.next_two_word) begin
									s_next.pc = s_reg.pc + 16'h0003;
									wait_n = 2'(cpubl_pkg::CYC_SKIP_TWO - 1);
								end else begin
									s_next.pc = s_reg.pc + 16'h0002;
									wait_n = 2'(cpubl_pkg::CYC_SKIP_ONE - 1);
								end
							end
						end
						cpubl_pkg::OP_BRANCH_STATUS_BIT_SET,
						cpubl_pkg::OP_BRANCH_STATUS_BIT_CLEAR,
						cpubl_pkg::OP_BRANCH_SIGNED_GE,
						cpubl_pkg::OP_BRANCH_SIGNED_LT: begin
							if (br_taken) begin
								s_next.pc = s_reg.pc + k_ext + 16'h0001;
								wait_n = 2'(cpubl_pkg::CYC_BRANCH_TAKEN - 1);
							end
						end
						cpubl_pkg::OP_LOAD_INDIRECT: begin
							s_next.dmem.addr = ptr_addr;
							s_next.dmem.re   = 1'b1;
							if (instr.amode == cpubl_pkg::AM_PREDEC) begin
								s_next.rf[ptr_lo]         = ptr_addr[7:0];
								s_next.rf[ptr_lo | 5'h01] = ptr_addr[15:8];
							end
							wait_n = 2'(cpubl_pkg::CYC_MEM - 1);
						end
						cpubl_pkg::OP_STORE_INDIRECT: begin
							s_next.dmem.addr  = ptr_addr;
							s_next.dmem.wdata = s_reg.rf[instr.rr];
							s_next.dmem.we    = 1'b1;
							if (instr.amode == cpubl_pkg::AM_PREDEC) begin
								s_next.rf[ptr_lo]         = ptr_addr[7:0];
								s_next.rf[ptr_lo | 5'h01] = ptr_addr[15:8];
							end
							wait_n = 2'(cpubl_pkg::CYC_MEM - 1);
						end
						cpubl_pkg::OP_LOAD_DIRECT: begin
							s_next.dmem.addr = instr.addr;
							s_next.dmem.re   = 1'b1;
							wait_n = 2'(cpubl_pkg::CYC_MEM - 1);
						end
						cpubl_pkg::OP_STORE_DIRECT: begin
							s_next.dmem.addr  = instr.addr;
							s_next.dmem.wdata = s_reg.rf[instr.rr];
							s_next.dmem.we    = 1'b1;
							wait_n = 2'(cpubl_pkg::CYC_MEM - 1);
						end
						cpubl_pkg::OP_PROGRAM_MEMORY_READ,
						cpubl_pkg::OP_PROGRAM_MEMORY_READ_R0: begin
							s_next.pmem.addr = z_val;
							s_next.pmem.re   = 1'b1;
							wait_n = 2'(cpubl_pkg::CYC_PROGRAM_READ - 1);
						end
						cpubl_pkg::OP_PUSH: begin
							s_next.dmem.addr  = s_reg.sp;
							s_next.dmem.wdata = s_reg.rf[instr.rr];
							s_next.dmem.we    = 1'b1;
							s_next.sp         = s_reg.sp - 16'h0001;
							wait_n = 2'(cpubl_pkg::CYC_MEM - 1);
						end
						cpubl_pkg::OP_POP: begin
							s_next.dmem.addr = sp_up;
							s_next.dmem.re   = 1'b1;
							s_next.sp        = sp_up;
							wait_n = 2'(cpubl_pkg::CYC_MEM - 1);
						end
						cpubl_pkg::OP_IO_BIT_SET: begin
							s_next.io.wdata = io_rdata | bit_mask;
							s_next.io.we    = 1'b1;
							wait_n = 2'(cpubl_pkg::CYC_IO_BIT - 1);
						end
						cpubl_pkg::OP_IO_BIT_CLEAR: begin
							s_next.io.wdata = io_rdata & ~bit_mask;
							s_next.io.we    = 1'b1;
							wait_n = 2'(cpubl_pkg::CYC_IO_BIT - 1);
						end
						cpubl_pkg::OP_SHIFT_LEFT_LOGICAL,
						cpubl_pkg::OP_SHIFT_RIGHT_LOGICAL,
						cpubl_pkg::OP_ROTATE_LEFT_CARRY,
						cpubl_pkg::OP_ROTATE_RIGHT_CARRY,
						cpubl_pkg::OP_SHIFT_RIGHT_ARITH: begin
							s_next.rf[instr.rd]              = sh_res;
							s_next.flags[cpubl_pkg::FLAG_Z] = sh_z;
							s_next.flags[cpubl_pkg::FLAG_C] = sh_c;
							s_next.flags[cpubl_pkg::FLAG_N] = sh_n;
							s_next.flags[cpubl_pkg::FLAG_V] = sh_v;
						end
						cpubl_pkg::OP_BIT_TO_TFLAG:
							s_next.flags[cpubl_pkg::FLAG_T] = s_reg.rf[instr.rr][instr.bit_sel];
						cpubl_pkg::OP_TFLAG_TO_BIT:
							s_next.rf[instr.rd][instr.bit_sel] = s_reg.flags[cpubl_pkg::FLAG_T];
						cpubl_pkg::OP_FLAG_SET:   s_next.flags[instr.bit_sel] = 1'b1;
						cpubl_pkg::OP_FLAG_CLEAR: s_next.flags[instr.bit_sel] = 1'b0;
						cpubl_pkg::OP_MOVE:       s_next.rf[instr.rd] = s_reg.rf[instr.rr];
						cpubl_pkg::OP_REGISTER_PAIR_COPY: begin
							s_next.rf[instr.rd]         = s_reg.rf[instr.rr];
							s_next.rf[instr.rd | 5'h01] = s_reg.rf[instr.rr | 5'h01];
						end
						cpubl_pkg::OP_LOAD_IMMEDIATE: s_next.rf[instr.rd] = instr.imm;
						default: begin
						end
					endcase
					// multi-clock instructions hold the core busy
					if (wait_n != 2'h0) begin
						s_next.fsm      = cpubl_pkg::S_BUSY;
						s_next.wait_cnt = wait_n;
						s_next.retire   = 1'b0;
					end
				end
			end
			cpubl_pkg::S_BUSY: begin
				if (s_reg.wait_cnt != 2'h1) begin
					s_next.wait_cnt = s_reg.wait_cnt - 2'h1;
				end else begin
					// last clock: capture read data, release strobes
					s_next.fsm      = cpubl_pkg::S_IDLE;
					s_next.wait_cnt = 2'h0;
					s_next.retire   = 1'b1;
					s_next.dmem.re  = 1'b0;
					s_next.dmem.we  = 1'b0;
					s_next.pmem.re  = 1'b0;
					s_next.io.we    = 1'b0;
					case (s_reg.cur.op)
						cpubl_pkg::OP_LOAD_INDIRECT,
						cpubl_pkg::OP_LOAD_DIRECT,
						cpubl_pkg::OP_POP:          s_next.rf[s_reg.cur.rd] = dmem_rdata;
						cpubl_pkg::OP_PROGRAM_MEMORY_READ:    s_next.rf[s_reg.cur.rd] = pmem_rdata;
						cpubl_pkg::OP_PROGRAM_MEMORY_READ_R0: s_next.rf[5'h00] = pmem_rdata;
						default: begin
						end
					endcase
					// post-increment lands after the data move
					if (s_reg.cur.amode == cpubl_pkg::AM_POSTINC &&
					    (s_reg.cur.op == cpubl_pkg::OP_LOAD_INDIRECT ||
					     s_reg.cur.op == cpubl_pkg::OP_STORE_INDIRECT ||
					     s_reg.cur.op == cpubl_pkg::OP_PROGRAM_MEMORY_READ)) begin
						s_next.rf[cur_lo]         = 8'((cur_ptr_val + 16'h0001) & 16'h00FF);
						s_next.rf[cur_lo | 5'h01] = 8'((cur_ptr_val + 16'h0001) >> 8);
					end
				end
			end
			default: s_next.fsm = cpubl_pkg::S_IDLE;
		endcase
	end

	// state register, frozen while ce is low
	always_ff @(posedge mclk) begin
		if (rst) begin
			s_reg       <= '0;
			s_reg.pc    <= cpubl_pkg::PC_RESET;
			s_reg.sp    <= cpubl_pkg::SP_RESET;
			s_reg.flags <= cpubl_pkg::FLAGS_RESET;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst || !ce);

	sequence seq_one_wait;
		(s_reg.fsm == cpubl_pkg::S_BUSY) ##1 (s_reg.fsm == cpubl_pkg::S_IDLE && retire);
	endsequence

	sequence seq_two_wait;
		(s_reg.fsm == cpubl_pkg::S_BUSY) [*2] ##1 (s_reg.fsm == cpubl_pkg::S_IDLE && retire);
	endsequence

	AST_SKIP_ONE_WORD: assert property (
		accept && instr.op == cpubl_pkg::OP_SKIP_IF_IO_BIT_SET &&
		io_rdata[instr.bit_sel] && !instr.next_two_word
		|=> (s_reg.pc == $past(s_reg.pc) + 16'h0002) and seq_one_wait)
		else $error("skip over one word wrong");

	AST_BRANCH_TAKEN: assert property (
		accept && instr.op == cpubl_pkg::OP_BRANCH_STATUS_BIT_SET &&
		s_reg.flags[instr.bit_sel]
		|=> s_reg.pc == $past(s_reg.pc) + $past(k_ext) + 16'h0001 ##1 retire)
		else $error("taken flag branch target or timing wrong");

	AST_SIGNED_GE_FALL: assert property (
		accept && instr.op == cpubl_pkg::OP_BRANCH_SIGNED_GE &&
		(s_reg.flags[cpubl_pkg::FLAG_N] != s_reg.flags[cpubl_pkg::FLAG_V])
		|=> retire && s_reg.pc == $past(s_reg.pc) + 16'h0001)
		else $error("signed ge branch taken on N xor V set");

	AST_BRANCH_KEEPS_FLAGS: assert property (
		accept && instr.op inside {cpubl_pkg::OP_BRANCH_STATUS_BIT_SET,
		cpubl_pkg::OP_BRANCH_STATUS_BIT_CLEAR}
		|=> $stable(s_reg.flags))
		else $error("branch altered status flags");

	AST_LOAD_TWO_CLOCKS: assert property (
		accept && instr.op inside {cpubl_pkg::OP_LOAD_INDIRECT, cpubl_pkg::OP_POP}
		|=> dmem_req.re ##1 (!dmem_req.re && retire))
		else $error("load did not finish in two clocks");

	AST_STORE_STROBE: assert property (
		accept && instr.op == cpubl_pkg::OP_STORE_INDIRECT
		|=> dmem_req.we && dmem_req.wdata == $past(s_reg.rf[instr.rr]) ##1 !dmem_req.we)
		else $error("store strobe or data wrong");

	AST_PROGRAM_READ_THREE: assert property (
		accept && instr.op == cpubl_pkg::OP_PROGRAM_MEMORY_READ
		|=> pmem_req.addr == $past(z_val) and seq_two_wait)
		else $error("program read address or timing wrong");

	AST_IO_BIT_SET: assert property (
		accept && instr.op == cpubl_pkg::OP_IO_BIT_SET
		|=> io_wr.we && io_wr.wdata == ($past(io_rdata) | $past(bit_mask)))
		else $error("io bit set wrote wrong value");

	AST_SHIFT_LEFT: assert property (
		accept && instr.op == cpubl_pkg::OP_SHIFT_LEFT_LOGICAL
		|=> retire && s_reg.flags[cpubl_pkg::FLAG_C] == $past(s_reg.rf[instr.rd][7]))
		else $error("left shift carry wrong");

	AST_BIT_TO_T: assert property (
		accept && instr.op == cpubl_pkg::OP_BIT_TO_TFLAG
		|=> s_reg.flags[cpubl_pkg::FLAG_T] == $past(s_reg.rf[instr.rr][instr.bit_sel]))
		else $error("T flag not loaded from register bit");

	AST_FLAG_SET_ONLY: assert property (
		accept && instr.op == cpubl_pkg::OP_FLAG_SET
		|=> s_reg.flags == ($past(s_reg.flags) | $past(bit_mask)))
		else $error("flag set touched other flags");

	AST_SLEEP_THREE: assert property (
		accept && instr.op == cpubl_pkg::OP_SLEEP
		|=> sleep_req ##0 seq_two_wait)
		else $error("sleep timing wrong");

endmodule

`default_nettype wire

// *** pkg/cpubl_pkg.sv ***
package cpubl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	////////////////////////////////////////////////////////////////////////////////
	// register file layout and reset values
	localparam int          REG_COUNT    = 32;
	localparam int          PTR_BASE_IDX = 26;     // pointer pairs start at r26
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam logic [15:0] SP_RESET     = 16'h0000;
	localparam logic [7:0]  FLAGS_RESET  = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// clocks per instruction class
	localparam int CYC_SINGLE       = 1;
	localparam int CYC_BRANCH_TAKEN = 2;
	localparam int CYC_SKIP_ONE     = 2;
	localparam int CYC_SKIP_TWO     = 3;
	localparam int CYC_MEM          = 2;
	localparam int CYC_IO_BIT       = 2;
	localparam int CYC_PROGRAM_READ = 3;
	localparam int CYC_SLEEP        = 3;

	////////////////////////////////////////////////////////////////////////////////
	// decoded operations
	typedef enum logic [4:0] {
		OP_NOP,
		OP_SLEEP,
		OP_WATCHDOG_KICK,
		OP_SKIP_IF_IO_BIT_SET,
		OP_BRANCH_STATUS_BIT_SET,
		OP_BRANCH_STATUS_BIT_CLEAR,
		OP_BRANCH_SIGNED_GE,
		OP_BRANCH_SIGNED_LT,
		OP_LOAD_INDIRECT,
		OP_STORE_INDIRECT,
		OP_LOAD_DIRECT,
		OP_STORE_DIRECT,
		OP_PROGRAM_MEMORY_READ,
		OP_PROGRAM_MEMORY_READ_R0,
		OP_PUSH,
		OP_POP,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_SHIFT_LEFT_LOGICAL,
		OP_SHIFT_RIGHT_LOGICAL,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_SHIFT_RIGHT_ARITH,
		OP_BIT_TO_TFLAG,
		OP_TFLAG_TO_BIT,
		OP_FLAG_SET,
		OP_FLAG_CLEAR,
		OP_MOVE,
		OP_REGISTER_PAIR_COPY,
		OP_LOAD_IMMEDIATE
	} cpubl_op_t;

	typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} cpubl_ptr_t;

	typedef enum logic [1:0] {AM_PLAIN, AM_POSTINC, AM_PREDEC, AM_DISPLACED} cpubl_amode_t;

	typedef enum logic {S_IDLE, S_BUSY} cpubl_fsm_t;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		cpubl_op_t    op;
		logic [4:0]   rd;
		logic [4:0]   rr;
		logic [7:0]   imm;
		logic [6:0]   koff;
		logic [15:0]  addr;
		logic [5:0]   q;
		logic [2:0]   bit_sel;
		logic [5:0]   io_addr;
		cpubl_ptr_t   ptr;
		cpubl_amode_t amode;
		logic         next_two_word;
	} cpubl_instr_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        we;
		logic        re;
	} cpubl_dmem_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        re;
	} cpubl_pmem_req_t;

	typedef struct packed {
		logic [7:0] wdata;
		logic       we;
	} cpubl_io_wr_t;

endpackage

// *** hdl/cpubl_shift_unit.sv ***
`timescale 1ns/1ps
`default_nettype none

module cpubl_shift_unit #(
	parameter int W = 8
) (
	input  wire cpubl_pkg::cpubl_op_t sel,
	input  wire logic [W-1:0]         a,
	input  wire logic                 c_in,
	output logic [W-1:0]              res,
	output logic                      z,
	output logic                      c,
	output logic                      n,
	output logic                      v
);

	////////////////////////////////////////////////////////////////////////////////
	// shift or rotate, bit moved out goes to carry
	always_comb begin
		res = a;
		c   = c_in;
		case (sel)
			cpubl_pkg::OP_SHIFT_LEFT_LOGICAL: begin
				res = {a[W-2:0], 1'b0};
				c   = a[W-1];
			end
			cpubl_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
				res = {1'b0, a[W-1:1]};
				c   = a[0];
			end
			cpubl_pkg::OP_ROTATE_LEFT_CARRY: begin
				res = {a[W-2:0], c_in};
				c   = a[W-1];
			end
			cpubl_pkg::OP_ROTATE_RIGHT_CARRY: begin
				res = {c_in, a[W-1:1]};
				c   = a[0];
			end
			cpubl_pkg::OP_SHIFT_RIGHT_ARITH: begin
				res = {a[W-1], a[W-1:1]};
				c   = a[0];
			end
			default: begin
			end
		endcase
	end

	// result flags
	assign z = (res == '0);
	assign n = res[W-1];
	assign v = res[W-1] ^ c;

endmodule

`default_nettype wire

// *** verification/cpubl_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// data, program and io memories facing the core
module cpubl_mem_model (
	input  wire logic                       mclk,
	input  wire cpubl_pkg::cpubl_dmem_req_t dmem_req,
	output logic [7:0]                      dmem_rdata,
	input  wire cpubl_pkg::cpubl_pmem_req_t pmem_req,
	output logic [7:0]                      pmem_rdata,
	input  wire logic [5:0]                 io_addr,
	output logic [7:0]                      io_rdata,
	input  wire cpubl_pkg::cpubl_io_wr_t    io_wr
);
	logic [7:0] dmem [256];
	logic [7:0] io_reg [64];
	logic [7:0] pbyte;
	// known fill so loads give checkable values
	initial begin
		for (int i = 0; i < 256; i++) dmem[i] = 8'(i) ^ 8'h3C;
		for (int i = 0; i < 64; i++) io_reg[i] = 8'h00;
	end
	// writes land on the clock edge
	always @(posedge mclk) begin
		if (dmem_req.we) dmem[dmem_req.addr[7:0]] <= dmem_req.wdata;
		if (io_wr.we) io_reg[io_addr] <= io_wr.wdata;
	end
	// data and program read data valid only while requested, inverted otherwise; io read data always valid
	assign pbyte      = pmem_req.addr[7:0] ^ 8'h5A;
	assign dmem_rdata = dmem_req.re ? dmem[dmem_req.addr[7:0]] : ~dmem[dmem_req.addr[7:0]];
	assign pmem_rdata = pmem_req.re ? pbyte : ~pbyte;
	assign io_rdata   = io_reg[io_addr];
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {
		cpubl_pkg::cpubl_instr_t i;
		logic [1:0]              n;
		logic [15:0]             d;
		logic [4:0]              ci;
		logic [7:0]              cv;
		logic [7:0]              f;
	} cpubl_row_t;
	logic                       mclk, rst, ce, instr_valid, instr_ready, retire;
	logic                       wdt_kick, sleep_req;
	logic [15:0]                pc, sp, pc0;
	logic [7:0]                 status_flags, dmem_rdata, pmem_rdata, io_rdata, view_data;
	logic [5:0]                 io_addr;
	logic [4:0]                 view_idx;
	cpubl_pkg::cpubl_instr_t    instr;
	cpubl_pkg::cpubl_dmem_req_t dmem_req;
	cpubl_pkg::cpubl_pmem_req_t pmem_req;
	cpubl_pkg::cpubl_io_wr_t    io_wr;
	cpubl_row_t                 rows[$];
	int                         err_count, cmp_count, n;
	cpubl_exec_core i_cpubl_exec_core (.mclk, .rst, .ce, .instr_valid, .instr, .instr_ready,
		.retire, .pc, .sp, .status_flags, .dmem_req, .dmem_rdata, .pmem_req, .pmem_rdata,
		.io_addr, .io_rdata, .io_wr, .wdt_kick, .sleep_req, .view_idx, .view_data);
	cpubl_mem_model i_cpubl_mem_model (.mclk, .dmem_req, .dmem_rdata, .pmem_req, .pmem_rdata,
		.io_addr, .io_rdata, .io_wr);
	////////////////////////////////////////
	// value compare
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// verdict and end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// one row: v feeds imm, koff, q, bit select; pa is {ptr, amode}; skip of 2 clocks is one-word
	task automatic add(input cpubl_pkg::cpubl_op_t op, input logic [4:0] a, b,
		input logic [7:0] v, input logic [3:0] pa, input logic [1:0] cy,
		input logic [7:0] d, input logic [4:0] ci, input logic [7:0] cv, f);
		rows.push_back(cpubl_row_t'{'{op, a, b, v, v[6:0], 16'h0040, v[5:0], v[2:0], 6'h05,
			cpubl_pkg::cpubl_ptr_t'(pa[3:2]), cpubl_pkg::cpubl_amode_t'(pa[1:0]), cy != 2'h2},
			cy, {{8{d[7]}}, d}, ci, cv, f});
	endtask
	// issue one row, count clocks to retire, then check pc, flags and a register
	task automatic run(input cpubl_row_t r);
		pc0 = pc;
		instr = r.i;
		instr_valid = 1'b1;
		@(posedge mclk);
		#2;
		instr_valid = 1'b0;
		n = 1;
		while (retire !== 1'b1 && n < 9) begin
			@(posedge mclk);
			#2;
			n++;
		end
		check(16'(n), {14'h0000, r.n});
		check(pc, pc0 + r.d);
		check({8'h00, status_flags}, {8'h00, r.f});
		view_idx = r.ci;
		@(posedge mclk);
		#2;
		check({8'h00, view_data}, {8'h00, r.cv});
	endtask
	////////////////////////////////////////
	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// watchdog well past the hundred or so cycles the tests need
	initial begin
		#20000;
		err_count++;
		results();
	end
	// main sequence
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		instr_valid = 1'b0;
		instr = '0;
		view_idx = 5'h00;
		err_count = 0;
		cmp_count = 0;
		add(cpubl_pkg::OP_LOAD_IMMEDIATE, 5'h1A, 5'h00, 8'h0A, 4'h0, 2'h1, 8'h01, 5'h1A, 8'h0A, 8'h00);
		add(cpubl_pkg::OP_LOAD_IMMEDIATE, 5'h11, 5'h00, 8'h81, 4'h0, 2'h1, 8'h01, 5'h11, 8'h81, 8'h00);
		add(cpubl_pkg::OP_SHIFT_LEFT_LOGICAL, 5'h11, 5'h11, 8'h00, 4'h0, 2'h1, 8'h01, 5'h11, 8'h02, 8'h09);
		add(cpubl_pkg::OP_ROTATE_RIGHT_CARRY, 5'h11, 5'h11, 8'h00, 4'h0, 2'h1, 8'h01, 5'h11, 8'h81, 8'h0C);
		add(cpubl_pkg::OP_SHIFT_RIGHT_ARITH, 5'h11, 5'h11, 8'h00, 4'h0, 2'h1, 8'h01, 5'h11, 8'hC0, 8'h05);
		add(cpubl_pkg::OP_BIT_TO_TFLAG, 5'h11, 5'h11, 8'h07, 4'h0, 2'h1, 8'h01, 5'h11, 8'hC0, 8'h45);
		add(cpubl_pkg::OP_TFLAG_TO_BIT, 5'h12, 5'h12, 8'h03, 4'h0, 2'h1, 8'h01, 5'h12, 8'h08, 8'h45);
		add(cpubl_pkg::OP_STORE_INDIRECT, 5'h11, 5'h11, 8'h00, 4'h1, 2'h2, 8'h01, 5'h1A, 8'h0B, 8'h45);
		add(cpubl_pkg::OP_LOAD_INDIRECT, 5'h13, 5'h13, 8'h00, 4'h2, 2'h2, 8'h01, 5'h13, 8'hC0, 8'h45);
		add(cpubl_pkg::OP_LOAD_INDIRECT, 5'h14, 5'h14, 8'h00, 4'h1, 2'h2, 8'h01, 5'h1A, 8'h0B, 8'h45);
		add(cpubl_pkg::OP_LOAD_INDIRECT, 5'h15, 5'h15, 8'h02, 4'h7, 2'h2, 8'h01, 5'h15, 8'h3E, 8'h45);
		add(cpubl_pkg::OP_STORE_DIRECT, 5'h11, 5'h11, 8'h00, 4'h0, 2'h2, 8'h01, 5'h11, 8'hC0, 8'h45);
		add(cpubl_pkg::OP_LOAD_DIRECT, 5'h16, 5'h16, 8'h00, 4'h0, 2'h2, 8'h01, 5'h16, 8'hC0, 8'h45);
		add(cpubl_pkg::OP_PUSH, 5'h11, 5'h11, 8'h00, 4'h0, 2'h2, 8'h01, 5'h11, 8'hC0, 8'h45);
		add(cpubl_pkg::OP_POP, 5'h17, 5'h17, 8'h00, 4'h0, 2'h2, 8'h01, 5'h17, 8'hC0, 8'h45);
		add(cpubl_pkg::OP_PROGRAM_MEMORY_READ, 5'h18, 5'h18, 8'h00, 4'h9, 2'h3, 8'h01, 5'h1E, 8'h01, 8'h45);
		add(cpubl_pkg::OP_PROGRAM_MEMORY_READ_R0, 5'h00, 5'h00, 8'h00, 4'h8, 2'h3, 8'h01, 5'h00, 8'h5B, 8'h45);
		add(cpubl_pkg::OP_FLAG_SET, 5'h00, 5'h00, 8'h05, 4'h0, 2'h1, 8'h01, 5'h00, 8'h5B, 8'h65);
		add(cpubl_pkg::OP_FLAG_CLEAR, 5'h00, 5'h00, 8'h00, 4'h0, 2'h1, 8'h01, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_BRANCH_STATUS_BIT_SET, 5'h00, 5'h00, 8'h06, 4'h0, 2'h2, 8'h07, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_BRANCH_SIGNED_GE, 5'h00, 5'h00, 8'h7E, 4'h0, 2'h1, 8'h01, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_BRANCH_SIGNED_LT, 5'h00, 5'h00, 8'h7E, 4'h0, 2'h2, 8'hFF, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_BRANCH_STATUS_BIT_CLEAR, 5'h00, 5'h00, 8'h03, 4'h0, 2'h2, 8'h04, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_IO_BIT_SET, 5'h00, 5'h00, 8'h02, 4'h0, 2'h2, 8'h01, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_SKIP_IF_IO_BIT_SET, 5'h00, 5'h00, 8'h02, 4'h0, 2'h3, 8'h03, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_IO_BIT_CLEAR, 5'h00, 5'h00, 8'h02, 4'h0, 2'h2, 8'h01, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_SKIP_IF_IO_BIT_SET, 5'h00, 5'h00, 8'h02, 4'h0, 2'h1, 8'h01, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_IO_BIT_SET, 5'h00, 5'h00, 8'h02, 4'h0, 2'h2, 8'h01, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_SKIP_IF_IO_BIT_SET, 5'h00, 5'h00, 8'h02, 4'h0, 2'h2, 8'h02, 5'h00, 8'h5B, 8'h64);
		add(cpubl_pkg::OP_REGISTER_PAIR_COPY, 5'h02, 5'h1A, 8'h00, 4'h0, 2'h1, 8'h01, 5'h02, 8'h0B, 8'h64);
		add(cpubl_pkg::OP_MOVE, 5'h19, 5'h11, 8'h00, 4'h0, 2'h1, 8'h01, 5'h19, 8'hC0, 8'h64);
		add(cpubl_pkg::OP_WATCHDOG_KICK, 5'h00, 5'h00, 8'h00, 4'h0, 2'h1, 8'h01, 5'h19, 8'hC0, 8'h64);
		add(cpubl_pkg::OP_SLEEP, 5'h00, 5'h00, 8'h00, 4'h0, 2'h3, 8'h01, 5'h02, 8'h0B, 8'h64);
		repeat (4) @(posedge mclk);
		#2;
		rst = 1'b0;
		foreach (rows[k]) run(rows[k]);
		check(sp, 16'h0000);
		$display("instruction table done");
		// clock enable low: offer refused, pc frozen
		ce = 1'b0;
		pc0 = pc;
		instr_valid = 1'b1;
		repeat (2) @(posedge mclk);
		#2;
		check(pc, pc0);
		check({15'h0000, instr_ready}, 16'h0000);
		ce = 1'b1;
		instr_valid = 1'b0;
		$display("clock enable test done");
		// second reset brings pc and flags home
		rst = 1'b1;
		@(posedge mclk);
		#2;
		rst = 1'b0;
		check(pc, cpubl_pkg::PC_RESET);
		check({8'h00, status_flags}, {8'h00, cpubl_pkg::FLAGS_RESET});
		$display("reset test done");
		results();
	end
endmodule
`default_nettype wire
